// >>> include/psc_regs.vh
// Register map, field positions and timing constants of the port-five strap block
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PSC_OFF_CFG 8'h00
`define PSC_OFF_STATUS 8'h04
`define PSC_OFF_CTRL 8'h08
`define PSC_OFF_RXDRV 8'h0c

// ****************************************************************
// Reset values
// ****************************************************************
`define PSC_CTRL_RST 1'b0
`define PSC_RXDRV_RST 8'h00

// ****************************************************************
// Strap vector positions, also the CFG register layout
// ****************************************************************
`define PSC_STRAP_BACKOFF 0
`define PSC_STRAP_COLL_DROP 1
`define PSC_STRAP_BACKPRESSURE 2
`define PSC_STRAP_FLOWCTL 3
`define PSC_STRAP_PKTSIZE 4
`define PSC_STRAP_DUPLEX 5
`define PSC_STRAP_FORCE_FC 6
`define PSC_PIN_RX_VALID 7
`define PSC_STRAP_COUNT 7
`define PSC_PIN_COUNT 8

// ****************************************************************
// STATUS register layout
// ****************************************************************
`define PSC_ST_POWERDOWN 0
`define PSC_ST_TEST_LO 1
`define PSC_ST_TEST_HI 2
`define PSC_ST_TX_ENABLE 3
`define PSC_ST_TX_DATA_LO 4
`define PSC_ST_TX_DATA_HI 7
`define PSC_ST_TX_ERROR 8

// ****************************************************************
// CTRL and RXDRV layouts
// ****************************************************************
`define PSC_CTRL_SPEED10 0
`define PSC_RXDRV_DATA_LO 0
`define PSC_RXDRV_DATA_HI 3
`define PSC_RXDRV_VALID 4
`define PSC_RXDRV_ERROR 5
`define PSC_RXDRV_CRS 6
`define PSC_RXDRV_COL 7

// ****************************************************************
// Test mode codes, {select_a, select_b}
// ****************************************************************
`define PSC_TEST_NORMAL 2'h0
`define PSC_TEST_LOOPBACK 2'h1
`define PSC_TEST_RESERVED 2'h2
`define PSC_TEST_PWRSAVE 2'h3

// ****************************************************************
// Packet length limits in bytes
// ****************************************************************
`define PSC_PKT_UNTAGGED 11'h5ee
`define PSC_PKT_TAGGED 11'h5f2
`define PSC_PKT_LONG 11'h600

// ****************************************************************
// Timing: periods in ns, half-period counts in sys_clk cycles
// ****************************************************************
`define PSC_SYS_PERIOD_NS 10
`define PSC_MII100_PERIOD_NS 40
`define PSC_MII10_PERIOD_NS 400
`define PSC_HALF_100 (`PSC_MII100_PERIOD_NS / (2 * `PSC_SYS_PERIOD_NS))
`define PSC_HALF_10 (`PSC_MII10_PERIOD_NS / (2 * `PSC_SYS_PERIOD_NS))

`endif

// >>> logic/psc_strap_pins.v
// Dual-purpose strap pins: input while in reset, driven output afterwards
`timescale 1ns/1ps
module psc_strap_pins #(
   parameter N = 8
) (
   input wire sys_clk,
   input wire rst,
   input wire [N-1:0] pin_in,
   input wire [N-1:0] drive_data,
   output wire [N-1:0] pin_out,
   output wire [N-1:0] pin_oe,
   output wire [N-1:0] captured
);

   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_pin
         reg cap;
         reg oe;
         reg dout;
         // Sampled on every rising sys_clk edge while in reset, so the last sample is the level at release
         always @(posedge sys_clk) begin
            if (rst) begin
               cap <= pin_in[i];
               oe <= 1'b0;
               dout <= 1'b0;
            end else begin
               oe <= 1'b1;
               dout <= drive_data[i];
            end
         end
         assign captured[i] = cap;
         assign pin_oe[i] = oe;
         assign pin_out[i] = dout;
      end
   endgenerate

endmodule

// >>> logic/psc_clk_div.v
// Divider that makes the MII transmit and receive clocks from sys_clk
`timescale 1ns/1ps
module psc_clk_div #(
   parameter W = 6
) (
   input wire sys_clk,
   input wire rst,
   input wire run,
   input wire [W-1:0] half_count,
   output reg clk_out
);

   reg [W-1:0] cnt;

   always @(posedge sys_clk) begin
      if (rst || !run) begin
         cnt <= {W{1'b0}};
         clk_out <= 1'b0;
      end else if (cnt >= half_count - {{(W-1){1'b0}}, 1'b1}) begin
         cnt <= {W{1'b0}};
         clk_out <= ~clk_out;
      end else begin
         cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// >>> logic/psc_port5_strap_cfg.v
// Port-five PHY-mode MII pins, reset-time strap capture, power-down and test decode
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_port5_strap_cfg #(
   parameter DIV_W = 6
) (
   input wire sys_clk,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // Dual-purpose receive-side pins
   input wire p5_rx_bit3_flowctl_strap_in,
   output wire p5_rx_bit3_flowctl_strap_out,
   output wire p5_rx_bit3_flowctl_strap_oe,
   input wire p5_rx_bit2_backpressure_strap_in,
   output wire p5_rx_bit2_backpressure_strap_out,
   output wire p5_rx_bit2_backpressure_strap_oe,
   input wire p5_rx_bit1_collision_drop_strap_in,
   output wire p5_rx_bit1_collision_drop_strap_out,
   output wire p5_rx_bit1_collision_drop_strap_oe,
   input wire p5_rx_bit0_backoff_strap_in,
   output wire p5_rx_bit0_backoff_strap_out,
   output wire p5_rx_bit0_backoff_strap_oe,
   input wire p5_rx_error_pktsize_strap_in,
   output wire p5_rx_error_pktsize_strap_out,
   output wire p5_rx_error_pktsize_strap_oe,
   input wire p5_carrier_sense_duplex_strap_in,
   output wire p5_carrier_sense_duplex_strap_out,
   output wire p5_carrier_sense_duplex_strap_oe,
   input wire p5_collision_force_fc_strap_in,
   output wire p5_collision_force_fc_strap_out,
   output wire p5_collision_force_fc_strap_oe,
   input wire p5_rx_valid_in,
   output wire p5_rx_valid_out,
   output wire p5_rx_valid_oe,
   // Transmit side from the MAC
   input wire p5_tx_enable,
   input wire p5_tx_bit3,
   input wire p5_tx_bit2,
   input wire p5_tx_bit1,
   input wire p5_tx_bit0,
   input wire p5_tx_error,
   output wire p5_tx_clock_out,
   output wire p5_rx_clock_out,
   // Chip-level controls
   input wire chip_powerdown_low,
   input wire test_select_a,
   input wire test_select_b,
   // Configuration toward the switch core
   output wire flow_ctl_enable,
   output wire backpressure_enable,
   output wire drop_excess_collision,
   output wire aggressive_backoff,
   output reg [10:0] max_untagged_len,
   output reg [10:0] max_tagged_len,
   output wire p4_force_full_duplex,
   output wire p4_force_flow_ctl,
   output reg chip_powered_down,
   output reg [1:0] test_mode,
   output reg remote_loopback,
   output reg power_save_test
);

   // ****************************************************************
   // Test select decode
   // ****************************************************************
   function [1:0] decode_test;
      input sel_a;
      input sel_b;
      begin
         case ({sel_a, sel_b})
            2'b01: decode_test = `PSC_TEST_LOOPBACK;
            2'b10: decode_test = `PSC_TEST_RESERVED;
            2'b11: decode_test = `PSC_TEST_PWRSAVE;
            default: decode_test = `PSC_TEST_NORMAL;
         endcase
      end
   endfunction

   localparam integer HALF_100_N = `PSC_HALF_100;
   localparam integer HALF_10_N = `PSC_HALF_10;
   localparam [DIV_W-1:0] HALF_100 = HALF_100_N[DIV_W-1:0];
   localparam [DIV_W-1:0] HALF_10 = HALF_10_N[DIV_W-1:0];

   wire [`PSC_PIN_COUNT-1:0] pin_in;
   wire [`PSC_PIN_COUNT-1:0] pin_out;
   wire [`PSC_PIN_COUNT-1:0] pin_oe;
   wire [`PSC_PIN_COUNT-1:0] captured;
   reg [`PSC_PIN_COUNT-1:0] drive_data;
   reg ctrl_speed10;
   reg [7:0] rxdrv;
   reg [8:0] tx_snapshot;
   wire [3:0] tx_data;
   wire mii_clk;
   wire [1:0] test_now;
   wire apb_setup;
   wire apb_write;
   wire addr_hit;

   // ****************************************************************
   // Pin packing
   // ****************************************************************
   assign pin_in = {p5_rx_valid_in, p5_collision_force_fc_strap_in, p5_carrier_sense_duplex_strap_in,
                    p5_rx_error_pktsize_strap_in, p5_rx_bit3_flowctl_strap_in, p5_rx_bit2_backpressure_strap_in,
                    p5_rx_bit1_collision_drop_strap_in, p5_rx_bit0_backoff_strap_in};

   assign p5_rx_bit0_backoff_strap_out = pin_out[`PSC_STRAP_BACKOFF];
   assign p5_rx_bit0_backoff_strap_oe = pin_oe[`PSC_STRAP_BACKOFF];
   assign p5_rx_bit1_collision_drop_strap_out = pin_out[`PSC_STRAP_COLL_DROP];
   assign p5_rx_bit1_collision_drop_strap_oe = pin_oe[`PSC_STRAP_COLL_DROP];
   assign p5_rx_bit2_backpressure_strap_out = pin_out[`PSC_STRAP_BACKPRESSURE];
   assign p5_rx_bit2_backpressure_strap_oe = pin_oe[`PSC_STRAP_BACKPRESSURE];
   assign p5_rx_bit3_flowctl_strap_out = pin_out[`PSC_STRAP_FLOWCTL];
   assign p5_rx_bit3_flowctl_strap_oe = pin_oe[`PSC_STRAP_FLOWCTL];
   assign p5_rx_error_pktsize_strap_out = pin_out[`PSC_STRAP_PKTSIZE];
   assign p5_rx_error_pktsize_strap_oe = pin_oe[`PSC_STRAP_PKTSIZE];
   assign p5_carrier_sense_duplex_strap_out = pin_out[`PSC_STRAP_DUPLEX];
   assign p5_carrier_sense_duplex_strap_oe = pin_oe[`PSC_STRAP_DUPLEX];
   assign p5_collision_force_fc_strap_out = pin_out[`PSC_STRAP_FORCE_FC];
   assign p5_collision_force_fc_strap_oe = pin_oe[`PSC_STRAP_FORCE_FC];
   assign p5_rx_valid_out = pin_out[`PSC_PIN_RX_VALID];
   assign p5_rx_valid_oe = pin_oe[`PSC_PIN_RX_VALID];

   psc_strap_pins #(
      .N(`PSC_PIN_COUNT)
   ) u_pins (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in(pin_in),
      .drive_data(drive_data),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .captured(captured)
   );

   // ****************************************************************
   // Configuration from captured straps
   // ****************************************************************
   assign flow_ctl_enable = ~captured[`PSC_STRAP_FLOWCTL];
   assign backpressure_enable = captured[`PSC_STRAP_BACKPRESSURE];
   assign drop_excess_collision = ~captured[`PSC_STRAP_COLL_DROP];
   assign aggressive_backoff = captured[`PSC_STRAP_BACKOFF];
   assign p4_force_full_duplex = captured[`PSC_STRAP_DUPLEX];
   assign p4_force_flow_ctl = captured[`PSC_STRAP_FORCE_FC];

   always @(posedge sys_clk) begin
      if (rst) begin
         max_untagged_len <= `PSC_PKT_UNTAGGED;
         max_tagged_len <= `PSC_PKT_TAGGED;
      end else if (captured[`PSC_STRAP_PKTSIZE]) begin
         max_untagged_len <= `PSC_PKT_LONG;
         max_tagged_len <= `PSC_PKT_LONG;
      end else begin
         max_untagged_len <= `PSC_PKT_UNTAGGED;
         max_tagged_len <= `PSC_PKT_TAGGED;
      end
   end

   // ****************************************************************
   // Power-down and test mode
   // ****************************************************************
   assign test_now = decode_test(test_select_a, test_select_b);

   always @(posedge sys_clk) begin
      if (rst) begin
         chip_powered_down <= 1'b0;
         test_mode <= `PSC_TEST_NORMAL;
         remote_loopback <= 1'b0;
         power_save_test <= 1'b0;
      end else begin
         chip_powered_down <= ~chip_powerdown_low;
         test_mode <= test_now;
         remote_loopback <= (test_now == `PSC_TEST_LOOPBACK);
         power_save_test <= (test_now == `PSC_TEST_PWRSAVE);
      end
   end

   // ****************************************************************
   // MII clocks toward the MAC
   // ****************************************************************
   psc_clk_div #(
      .W(DIV_W)
   ) u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(~chip_powered_down),
      .half_count(ctrl_speed10 ? HALF_10 : HALF_100),
      .clk_out(mii_clk)
   );

   assign p5_tx_clock_out = mii_clk;
   assign p5_rx_clock_out = mii_clk;

   // ****************************************************************
   // Receive-side drive data
   // ****************************************************************
   // Transmit nibble from the four MAC data inputs; an open input is not pulled low
   assign tx_data = {p5_tx_bit3, p5_tx_bit2, p5_tx_bit1, p5_tx_bit0};

   always @* begin
      drive_data = {`PSC_PIN_COUNT{1'b0}};
      if (chip_powered_down) begin
         drive_data = {`PSC_PIN_COUNT{1'b0}};
      end else if (remote_loopback) begin
         // Transmit side echoed back onto the receive side
         drive_data[`PSC_PIN_RX_VALID] = p5_tx_enable;
         drive_data[`PSC_STRAP_FLOWCTL] = tx_data[3];
         drive_data[`PSC_STRAP_BACKPRESSURE] = tx_data[2];
         drive_data[`PSC_STRAP_COLL_DROP] = tx_data[1];
         drive_data[`PSC_STRAP_BACKOFF] = tx_data[0];
         drive_data[`PSC_STRAP_PKTSIZE] = p5_tx_error;
         drive_data[`PSC_STRAP_DUPLEX] = p5_tx_enable;
      end else begin
         drive_data[`PSC_PIN_RX_VALID] = rxdrv[`PSC_RXDRV_VALID];
         drive_data[`PSC_STRAP_FLOWCTL] = rxdrv[3];
         drive_data[`PSC_STRAP_BACKPRESSURE] = rxdrv[2];
         drive_data[`PSC_STRAP_COLL_DROP] = rxdrv[1];
         drive_data[`PSC_STRAP_BACKOFF] = rxdrv[0];
         drive_data[`PSC_STRAP_PKTSIZE] = rxdrv[`PSC_RXDRV_ERROR];
         drive_data[`PSC_STRAP_DUPLEX] = rxdrv[`PSC_RXDRV_CRS];
         drive_data[`PSC_STRAP_FORCE_FC] = rxdrv[`PSC_RXDRV_COL];
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         tx_snapshot <= 9'h000;
      end else begin
         tx_snapshot <= {p5_tx_error, tx_data, p5_tx_enable, test_mode, chip_powered_down};
      end
   end

   // ****************************************************************
   // APB slave, zero wait states
   // ****************************************************************
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign addr_hit = (paddr == `PSC_OFF_CFG) || (paddr == `PSC_OFF_STATUS) ||
                     (paddr == `PSC_OFF_CTRL) || (paddr == `PSC_OFF_RXDRV);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;

   always @(posedge sys_clk) begin
      if (rst) begin
         ctrl_speed10 <= `PSC_CTRL_RST;
         rxdrv <= `PSC_RXDRV_RST;
      end else if (apb_write) begin
         if (paddr == `PSC_OFF_CTRL) begin
            ctrl_speed10 <= pwdata[`PSC_CTRL_SPEED10];
         end else if (paddr == `PSC_OFF_RXDRV) begin
            rxdrv <= pwdata[7:0];
         end
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (apb_setup) begin
         if (paddr == `PSC_OFF_CFG) begin
            prdata <= {25'h0000000, captured[`PSC_STRAP_COUNT-1:0]};
         end else if (paddr == `PSC_OFF_STATUS) begin
            prdata <= {23'h000000, tx_snapshot};
         end else if (paddr == `PSC_OFF_CTRL) begin
            prdata <= {31'h00000000, ctrl_speed10};
         end else if (paddr == `PSC_OFF_RXDRV) begin
            prdata <= {24'h000000, rxdrv};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// >>> bench/psc_port5_strap_cfg_asserts.sv
// Concurrent checks on the port-five strap block ports
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_port5_strap_cfg_asserts (
   input wire sys_clk,
   input wire rst,
   input wire p5_rx_bit3_flowctl_strap_in,
   input wire p5_rx_bit3_flowctl_strap_oe,
   input wire p5_rx_valid_oe,
   input wire flow_ctl_enable,
   input wire [10:0] max_untagged_len,
   input wire [10:0] max_tagged_len,
   input wire chip_powerdown_low,
   input wire chip_powered_down,
   input wire p5_tx_clock_out,
   input wire p5_rx_clock_out,
   input wire test_select_a,
   input wire test_select_b,
   input wire [1:0] test_mode,
   input wire remote_loopback,
   input wire power_save_test
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_oe_release:
   assert property ($fell(rst) |-> !p5_rx_valid_oe && !p5_rx_bit3_flowctl_strap_oe
      ##1 p5_rx_valid_oe && p5_rx_bit3_flowctl_strap_oe) else $error("pins not turned at reset release");
   chk_oe_held:
   assert property (!$past(rst) |-> p5_rx_valid_oe && p5_rx_bit3_flowctl_strap_oe) else $error("pin not driven");
   chk_flow_strap:
   assert property ($fell(rst) |-> flow_ctl_enable == !$past(p5_rx_bit3_flowctl_strap_in))
      else $error("flow control strap wrong");
   chk_cfg_held:
   assert property (!$past(rst) && !$past(rst, 2) |-> $stable(flow_ctl_enable) && $stable(max_untagged_len)
      && $stable(max_tagged_len)) else $error("configuration changed after reset");
   chk_len_pair:
   assert property (!$past(rst) |-> max_tagged_len == ((max_untagged_len == `PSC_PKT_LONG) ? `PSC_PKT_LONG
      : `PSC_PKT_TAGGED)) else $error("length limits inconsistent");
   chk_pd_follow:
   assert property (!$past(rst) |-> chip_powered_down == !$past(chip_powerdown_low)) else $error("power-down lag");
   chk_pd_clk_low:
   assert property (chip_powered_down [*4] |-> !p5_tx_clock_out) else $error("clock runs in power-down");
   chk_clk_pair:
   assert property (p5_tx_clock_out == p5_rx_clock_out) else $error("mii clocks differ");
   chk_clk_high:
   assert property ($rose(p5_tx_clock_out) |-> ##[1:20] !p5_tx_clock_out) else $error("clock high too long");
   chk_clk_low:
   assert property ($fell(p5_tx_clock_out) |-> ##1 !p5_tx_clock_out) else $error("clock low too short");
   chk_test_decode:
   assert property (!$past(rst) |-> test_mode == $past({test_select_a, test_select_b}))
      else $error("test decode wrong");
   chk_test_flags:
   assert property (!$past(rst) |-> remote_loopback == ($past({test_select_a, test_select_b}) == `PSC_TEST_LOOPBACK)
      && power_save_test == ($past({test_select_a, test_select_b}) == `PSC_TEST_PWRSAVE))
      else $error("test flags wrong");
endmodule

// >>> bench/psc_mac_model.sv
// Behavioural MAC on the far side of the port-five MII
`timescale 1ns/1ps
module psc_mac_model (
   input wire tx_clk,
   input wire send,
   input wire [5:0] frame,
   output reg p5_tx_enable,
   output reg [3:0] tx_data,
   output reg p5_tx_error
);
   initial begin
      {p5_tx_enable, tx_data, p5_tx_error} = 6'h00;
   end
   // Launch on the PHY transmit clock; idle lines rest low
   always @(posedge tx_clk) begin
      {p5_tx_enable, tx_data, p5_tx_error} <= send ? frame : 6'h00;
   end
endmodule

// >>> bench/psc_port5_strap_cfg_tb_top.sv
// Self-checking bench for the port-five strap block
`timescale 1ns/1ps
`include "psc_regs.vh"
module psc_port5_strap_cfg_tb_top;
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, obs_valid = 1'b0;
   logic chip_powerdown_low = 1'b1, test_select_a = 1'b0, test_select_b = 1'b0;
   logic [7:0] paddr = 8'h00, strap_v = 8'h00, s, r, lb;
   logic [5:0] frame = 6'h00;
   logic [31:0] pwdata = 32'h0, obs = 32'h0, seed = 32'h541b, ce;
   logic [31:0] exp_q[$];
   int err_count = 0, tests_run = 0;
   wire pready, pslverr, p5_tx_enable, p5_tx_error, p5_tx_clock_out, p5_rx_clock_out, flow_ctl_enable;
   wire backpressure_enable, drop_excess_collision, aggressive_backoff, p4_force_full_duplex, p4_force_flow_ctl;
   wire chip_powered_down, remote_loopback, power_save_test;
   wire [1:0] test_mode;
   wire [10:0] max_untagged_len, max_tagged_len;
   wire [31:0] prdata;
   wire [3:0] tx_data;
   wire [7:0] pin_i, pin_o, pin_e;
   wire [31:0] cfg_now = {4'h0, max_untagged_len, max_tagged_len, p4_force_flow_ctl, p4_force_full_duplex,
      aggressive_backoff, drop_excess_collision, backpressure_enable, flow_ctl_enable};
   // Board strap shows only while the pin is not driven
   assign pin_i = (pin_o & pin_e) | (strap_v & ~pin_e);
   always #5 sys_clk = ~sys_clk;
   psc_port5_strap_cfg #(.DIV_W(6)) u_psc_port5_strap_cfg (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .p5_tx_enable(p5_tx_enable), .p5_tx_error(p5_tx_error), .p5_tx_clock_out(p5_tx_clock_out),
      .p5_rx_clock_out(p5_rx_clock_out), .chip_powerdown_low(chip_powerdown_low), .test_select_a(test_select_a),
      .test_select_b(test_select_b), .flow_ctl_enable(flow_ctl_enable), .backpressure_enable(backpressure_enable),
      .drop_excess_collision(drop_excess_collision), .aggressive_backoff(aggressive_backoff),
      .max_untagged_len(max_untagged_len), .max_tagged_len(max_tagged_len),
      .p4_force_full_duplex(p4_force_full_duplex), .p4_force_flow_ctl(p4_force_flow_ctl),
      .chip_powered_down(chip_powered_down), .test_mode(test_mode),
      .remote_loopback(remote_loopback), .power_save_test(power_save_test),
      .p5_tx_bit3(tx_data[3]), .p5_tx_bit2(tx_data[2]), .p5_tx_bit1(tx_data[1]), .p5_tx_bit0(tx_data[0]),
      .p5_rx_bit0_backoff_strap_in(pin_i[0]), .p5_rx_bit0_backoff_strap_out(pin_o[0]),
      .p5_rx_bit0_backoff_strap_oe(pin_e[0]), .p5_rx_bit1_collision_drop_strap_in(pin_i[1]),
      .p5_rx_bit1_collision_drop_strap_out(pin_o[1]), .p5_rx_bit1_collision_drop_strap_oe(pin_e[1]),
      .p5_rx_bit2_backpressure_strap_in(pin_i[2]), .p5_rx_bit2_backpressure_strap_out(pin_o[2]),
      .p5_rx_bit2_backpressure_strap_oe(pin_e[2]), .p5_rx_bit3_flowctl_strap_in(pin_i[3]),
      .p5_rx_bit3_flowctl_strap_out(pin_o[3]), .p5_rx_bit3_flowctl_strap_oe(pin_e[3]),
      .p5_rx_error_pktsize_strap_in(pin_i[4]), .p5_rx_error_pktsize_strap_out(pin_o[4]),
      .p5_rx_error_pktsize_strap_oe(pin_e[4]), .p5_carrier_sense_duplex_strap_in(pin_i[5]),
      .p5_carrier_sense_duplex_strap_out(pin_o[5]), .p5_carrier_sense_duplex_strap_oe(pin_e[5]),
      .p5_collision_force_fc_strap_in(pin_i[6]), .p5_collision_force_fc_strap_out(pin_o[6]),
      .p5_collision_force_fc_strap_oe(pin_e[6]), .p5_rx_valid_in(pin_i[7]), .p5_rx_valid_out(pin_o[7]),
      .p5_rx_valid_oe(pin_e[7]));
   psc_mac_model u_psc_mac_model (.tx_clk(p5_tx_clock_out), .send(send), .frame(frame),
      .p5_tx_enable(p5_tx_enable), .tx_data(tx_data), .p5_tx_error(p5_tx_error));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic show(input logic [31:0] e, input logic [31:0] a);
      exp_q.push_back(e);
      obs <= a;
      obs_valid <= 1'b1;
      @(posedge sys_clk);
      obs_valid <= 1'b0;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      if (obs_valid || (psel && penable && !pwrite && pready === 1'b1)) begin
         tests_run++;
         if (exp_q.size() == 0 || (obs_valid ? obs : prdata) !== exp_q[0]) begin
            $display("unexpected at %0t: got %h expected %h", $time, obs_valid ? obs : prdata, exp_q[0]);
            err_count++;
         end
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
      if (psel && penable) begin
         tests_run++;
         if (pslverr !== (paddr > `PSC_OFF_RXDRV || paddr[1:0] != 2'h0)) begin
            $display("unexpected pslverr at %0t: got %h expected %h", $time, pslverr,
               (paddr > `PSC_OFF_RXDRV || paddr[1:0] != 2'h0));
            err_count++;
         end
      end
   end
   initial begin
      #100000;
      err_count++;
      finish_test;
   end
   // ****************************************
   // Scenarios: all-low, all-high and random straps
   // ****************************************
   initial begin
      for (int p = 0; p < 3; p++) begin
         seed = xs(seed);
         s = (p == 0) ? 8'h00 : (p == 1) ? 8'hff : seed[7:0];
         r = seed[15:8];
         @(posedge sys_clk);
         rst <= 1'b1;
         strap_v <= s;
         frame <= seed[21:16];
         repeat (3) @(posedge sys_clk);
         rst <= 1'b0;
         ce = {4'h0, s[4] ? `PSC_PKT_LONG : `PSC_PKT_UNTAGGED, s[4] ? `PSC_PKT_LONG : `PSC_PKT_TAGGED,
            s[6], s[5], s[0], ~s[1], s[2], ~s[3]};
         cyc(3);
         show(ce, cfg_now);
         rd(`PSC_OFF_CFG, {25'h0, s[6:0]});
         apb(1'b1, `PSC_OFF_RXDRV, {24'h0, r});
         rd(`PSC_OFF_RXDRV, {24'h0, r});
         rd(8'h10, 32'h0);
         cyc(2);
         show({16'h0, 8'hff, r[4], r[7], r[6], r[5], r[3:0]}, {16'h0, pin_e, pin_o});
         cyc(0);
         show(ce, cfg_now);
         apb(1'b1, `PSC_OFF_CTRL, 32'h1);
         rd(`PSC_OFF_CTRL, 32'h1);
         repeat (60) @(posedge sys_clk);
         apb(1'b1, `PSC_OFF_CTRL, 32'h0);
         send <= 1'b1;
         for (int c = 0; c < 4; c++) begin
            {test_select_a, test_select_b} <= c[1:0];
            cyc(10);
            lb = (c == 1) ? {frame[5], 1'b0, frame[5], frame[0], frame[4:1]} : {r[4], r[7], r[6], r[5], r[3:0]};
            show({20'h0, lb, c[1:0], c == 1, c == 3}, {20'h0, pin_o, test_mode, remote_loopback, power_save_test});
         end
         {test_select_a, test_select_b} <= 2'b00;
         // Let the test decode and the status snapshot settle before reading
         cyc(2);
         rd(`PSC_OFF_STATUS, {23'h0, frame[0], frame[4:1], frame[5], 3'h0});
         chip_powerdown_low <= 1'b0;
         cyc(6);
         show({23'h0, 8'h00, 1'b1}, {23'h0, pin_o, chip_powered_down});
         chip_powerdown_low <= 1'b1;
         send <= 1'b0;
         cyc(4);
         $display("pass %0d done", p);
      end
      finish_test;
   end
endmodule
bind psc_port5_strap_cfg psc_port5_strap_cfg_asserts u_psc_port5_strap_cfg_asserts (.sys_clk(sys_clk), .rst(rst),
   .p5_rx_bit3_flowctl_strap_in(p5_rx_bit3_flowctl_strap_in),
   .p5_rx_bit3_flowctl_strap_oe(p5_rx_bit3_flowctl_strap_oe),
   .p5_rx_valid_oe(p5_rx_valid_oe), .flow_ctl_enable(flow_ctl_enable),
   .max_untagged_len(max_untagged_len), .max_tagged_len(max_tagged_len),
   .chip_powerdown_low(chip_powerdown_low), .chip_powered_down(chip_powered_down),
   .p5_tx_clock_out(p5_tx_clock_out), .p5_rx_clock_out(p5_rx_clock_out),
   .test_select_a(test_select_a), .test_select_b(test_select_b), .test_mode(test_mode),
   .remote_loopback(remote_loopback), .power_save_test(power_save_test));
